// [verification/switch_global_storm_led_config_test.sv]
`include "sgsl_consts.svh"

module switch_global_storm_led_config_test import sgsl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // short periods keep the run small; expectations follow these values
  localparam int P100 = 700;
  localparam int P10 = 1500;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  sgsl_reg_req_s regReq = '0;
  logic [7:0] regRdData;
  logic regRdValid;
  logic ledSelLowStrap = 1'b0;
  logic ledSelHighStrap = 1'b0;
  sgsl_port_in_s portIn [3] = '{default: '0};
  logic [2:0] dropBcast;
  logic phyPowerSave;
  logic factoryTestMode;
  logic specialTpidMode;
  logic ledLow;
  logic ledHigh;
  int bad_count = 0;
  int n_tests = 0;
  logic [7:0] shadow [64];
  time tFall;
  time tPrev;

  // free-running bench clock
  always #20 clk = ~clk;

  sgsl_global_regs #(.NPORTS(3), .PERIOD100_CYC(P100), .PERIOD10_CYC(P10)) dut (
    .clk(clk), .nrst(nrst), .regReq(regReq), .regRdData(regRdData),
    .regRdValid(regRdValid), .ledSelLowStrap(ledSelLowStrap),
    .ledSelHighStrap(ledSelHighStrap), .portIn(portIn), .dropBcast(dropBcast),
    .phyPowerSave(phyPowerSave), .factoryTestMode(factoryTestMode),
    .specialTpidMode(specialTpidMode), .led_mode_sel_low(ledLow),
    .led_mode_sel_high(ledHigh));

  // port 1 has protection off, so its random blocks must never cause drops
  always @(posedge clk)
    portIn[1].blockSeen <= 1'($urandom);

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // one-cycle strobes, released on the next edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    regReq <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    regReq <= '0;
    @(negedge clk);
    chk("read valid", {15'h0, regRdValid}, 16'h0001);
    chk($sformatf("reg %h", a), {8'h00, regRdData}, {8'h00, e});
  endtask : rd

  // write then read on the very next edge, the tightest order the port allows
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    regReq <= '0;
    @(negedge clk);
    chk("back-to-back valid", {15'h0, regRdValid}, 16'h0001);
    chk("back-to-back data", {8'h00, regRdData}, {8'h00, d});
    @(negedge clk);
    chk("valid drops", {15'h0, regRdValid}, 16'h0000);
  endtask : wr_rd

  // documented reset contents; unmapped places read zero
  function automatic logic [7:0] rst_val(input logic [7:0] a, input logic ls);
    case (a)
      8'h07: return 8'h63;
      8'h08: return 8'h4E;
      8'h09, 8'h0A: return 8'h24;
      8'h0B: return 8'h08 | {6'h00, ls, 1'b0};
      default: return 8'h00;
    endcase
  endfunction : rst_val

  task automatic blocks(input int n);
    @(posedge clk);
    portIn[0].blockSeen <= 1'b1;
    repeat (n) @(posedge clk);
    portIn[0].blockSeen <= 1'b0;
  endtask : blocks

  // bounded wait for a falling drop flag, which marks a period boundary
  task automatic wait_fall();
    int n;
    logic prev;
    prev = dropBcast[0];
    for (n = 0; n < 2000; n++)
    begin
      @(negedge clk);
      if (prev === 1'b1 && dropBcast[0] === 1'b0)
        break;
      prev = dropBcast[0];
    end
    chk("period boundary", {15'h0, n < 2000}, 16'h0001);
    tPrev = tFall;
    tFall = $time;
  endtask : wait_fall

  initial
  begin
    logic ls;
    logic hs;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] pwr [4];
    void'($urandom(32'hEA8C8636));
    ls = 1'($urandom);
    hs = 1'($urandom);
    ledSelLowStrap = ls;
    ledSelHighStrap = hs;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    ledSelHighStrap <= ~hs;
    @(negedge clk);
    chk("led low", {15'h0, ledLow}, {15'h0, ls});
    chk("led high", {15'h0, ledHigh}, {15'h0, hs});
    for (int i = 6; i < 16; i++)
    begin
      shadow[i] = rst_val(8'(i), ls);
      rd(8'(i), shadow[i]);
    end
    // random storage traffic, power/LED register left out here
    repeat (24)
    begin
      a = 8'h06 + 8'($urandom % 9);
      a = (a == 8'h0B) ? 8'h0D : a;
      d = 8'($urandom);
      wr(a, d);
      shadow[a] = (a == 8'h06) ? (d & 8'h07) : ((a == 8'h0C) ? 8'h00 : d);
      rd(a, shadow[a]);
    end
    wr(8'h3F, 8'($urandom));
    rd(8'h3F, 8'h00);
    d = 8'($urandom);
    wr_rd(8'h0D, d);
    wr_rd(8'h08, ~d);
    wr_rd(8'h0E, d ^ 8'h5A);
    pwr = '{8'h40, 8'h00, 8'hFF, 8'($urandom)};
    foreach (pwr[i])
    begin
      d = pwr[i] & 8'hEF;
      wr(8'h0B, d);
      @(negedge clk);
      chk("power save", {15'h0, phyPowerSave}, {15'h0, d[6]});
      chk("led low", {15'h0, ledLow}, {15'h0, d[1]});
      chk("led high", {15'h0, ledHigh}, {15'h0, hs});
      chk("test mode", {15'h0, factoryTestMode}, 16'h0000);
      chk("special tag mode", {15'h0, specialTpidMode}, {15'h0, d[0]});
      rd(8'h0B, d & 8'h7F);
    end
    // threshold of one block, then lock onto the period grid
    wr(8'h06, 8'h00);
    wr(8'h07, 8'h01);
    portIn[0].stormEn <= 1'b1;
    blocks(1);
    wait_fall();
    blocks(1);
    @(negedge clk);
    chk("drop at limit", {15'h0, dropBcast[0]}, 16'h0001);
    wait_fall();
    @(posedge clk);
    portIn[0].isTenMbps <= 1'b1;
    blocks(1);
    wait_fall();
    chk("fast period", 16'((tFall - tPrev) / 40), 16'(P100));
    blocks(1);
    wait_fall();
    chk("slow period", 16'((tFall - tPrev) / 40), 16'(P10));
    // eleven-bit threshold 0x103 needs both bytes
    wr(8'h06, 8'h01);
    wr(8'h07, 8'h03);
    blocks(258);
    @(negedge clk);
    chk("below limit", {15'h0, dropBcast[0]}, 16'h0000);
    blocks(1);
    @(negedge clk);
    chk("at limit", {15'h0, dropBcast[0]}, 16'h0001);
    chk("disabled port", {15'h0, dropBcast[1]}, 16'h0000);
    chk("idle port", {15'h0, dropBcast[2]}, 16'h0000);
    tally_and_finish();
  end

  // hang guard, well beyond the expected run length
  initial
  begin
    #(40 * 20000);
    bad_count++;
    tally_and_finish();
  end
endmodule : switch_global_storm_led_config_test

// [verilog/sgsl_consts.svh]
`ifndef SGSL_CONSTS_SVH
`define SGSL_CONSTS_SVH
// How it works
// - Each input port's broadcast traffic is counted in 64-byte blocks and held to the threshold per period.
// - The measurement period is 67 ms on a 100 Mbps port and 500 ms on a 10 Mbps port.
// - After reset the low byte of the storm threshold holds 0x63.
// - The threshold is one value, this byte as low part and the preceding register's field as high part.
// - The three high threshold bits sit in the low field of the preceding register and reset to 000.
// - Bit 6 of the power/LED register turns PHY power save on when set, off when clear, reset 0.
// - Bit 1 of the power/LED register drives only the low LED-mode selector, reset from its strap.
// - The high LED-mode selector comes only from its strap latched at reset and cannot be written.

// register offsets
`define SGSL_OFF_STORM_HIGH 8'h06
`define SGSL_OFF_STORM_LOW 8'h07
`define SGSL_OFF_FACT_A 8'h08
`define SGSL_OFF_FACT_B 8'h09
`define SGSL_OFF_FACT_C 8'h0A
`define SGSL_OFF_PWR_LED 8'h0B
`define SGSL_OFF_RSVD 8'h0C
`define SGSL_OFF_USER_ONE 8'h0D
`define SGSL_OFF_USER_TWO 8'h0E

// reset values
`define SGSL_RST_STORM_HIGH 3'h0
`define SGSL_RST_STORM_LOW 8'h63
`define SGSL_RST_FACT_A 8'h4E
`define SGSL_RST_FACT_B 8'h24
`define SGSL_RST_FACT_C 8'h24
`define SGSL_RST_USER 8'h00
`define SGSL_RST_RSVD 8'h00
`define SGSL_RST_PWR_LED 8'h08

// power/LED register field positions
`define SGSL_BIT_PWR_SAVE 6
`define SGSL_BIT_TEST_MODE 4
`define SGSL_BIT_LED_LOW 1
`define SGSL_PWR_LED_WMASK 8'h7F

// storm measurement
`define SGSL_BLOCK_BYTES 64
`define SGSL_THRESH_W 11
`define SGSL_PERIOD_100_MS 67
`define SGSL_PERIOD_10_MS 500
`define SGSL_CLK_HZ 25000000
`define SGSL_PERIOD_100_CYC (64'd`SGSL_PERIOD_100_MS * 64'd`SGSL_CLK_HZ / 64'd1000)
`define SGSL_PERIOD_10_CYC (64'd`SGSL_PERIOD_10_MS * 64'd`SGSL_CLK_HZ / 64'd1000)
`define SGSL_PERIOD_CNT_W 24
`define SGSL_NPORTS 3
`endif

// [verilog/sgsl_global_regs.sv]
`include "sgsl_consts.svh"

module sgsl_global_regs #(
  parameter int unsigned NPORTS = `SGSL_NPORTS,
  parameter int unsigned PERIOD100_CYC = 32'(`SGSL_PERIOD_100_CYC),
  parameter int unsigned PERIOD10_CYC = 32'(`SGSL_PERIOD_10_CYC)
) (
  input wire logic clk,
  input wire logic nrst,
  input sgsl_pkg::sgsl_reg_req_s regReq,
  output logic [7:0] regRdData,
  output logic regRdValid,
  input wire logic ledSelLowStrap,
  input wire logic ledSelHighStrap,
  input sgsl_pkg::sgsl_port_in_s portIn [NPORTS],
  output logic [NPORTS-1:0] dropBcast,
  output logic phyPowerSave,
  output logic factoryTestMode,
  output logic specialTpidMode,
  output logic led_mode_sel_low,
  output logic led_mode_sel_high
);
  import sgsl_pkg::*;

  if (NPORTS < 1 || NPORTS > 8)
  begin : gPortCheck
    $error("NPORTS must be 1 to 8");
  end

  // register file state
  logic [2:0] stormHigh_q, stormHigh_d;
  logic [7:0] stormLow_q, stormLow_d;
  logic [7:0] factA_q, factA_d;
  logic [7:0] factB_q, factB_d;
  logic [7:0] factC_q, factC_d;
  logic [7:0] pwrLed_q, pwrLed_d;
  logic [7:0] userOne_q, userOne_d;
  logic [7:0] userTwo_q, userTwo_d;
  logic ledHigh_q, ledHigh_d;
  logic [7:0] rdData_q, rdData_d;
  logic rdValid_q, rdValid_d;
  sgsl_thresh_t threshold;

  // write decode; unmapped and reserved offsets drop writes silently
  always_comb
  begin
    stormHigh_d = stormHigh_q;
    stormLow_d = stormLow_q;
    factA_d = factA_q;
    factB_d = factB_q;
    factC_d = factC_q;
    pwrLed_d = pwrLed_q;
    userOne_d = userOne_q;
    userTwo_d = userTwo_q;
    ledHigh_d = ledHigh_q;
    if (regReq.wr)
    begin
      unique case (regReq.addr)
        `SGSL_OFF_STORM_HIGH: stormHigh_d = regReq.wdata[2:0];
        `SGSL_OFF_STORM_LOW: stormLow_d = regReq.wdata;
        `SGSL_OFF_FACT_A: factA_d = regReq.wdata;
        `SGSL_OFF_FACT_B: factB_d = regReq.wdata;
        `SGSL_OFF_FACT_C: factC_d = regReq.wdata;
        // bit 7 is read-only zero; test bit is stored as written, software must keep it 0
        `SGSL_OFF_PWR_LED: pwrLed_d = regReq.wdata & `SGSL_PWR_LED_WMASK;
        `SGSL_OFF_USER_ONE: userOne_d = regReq.wdata;
        `SGSL_OFF_USER_TWO: userTwo_d = regReq.wdata;
        default: ;
      endcase
    end
  end

  // read mux; answer comes one cycle after the request
  always_comb
  begin
    rdValid_d = regReq.rd;
    rdData_d = rdData_q;
    if (regReq.rd)
    begin
      unique case (regReq.addr)
        `SGSL_OFF_STORM_HIGH: rdData_d = {5'h00, stormHigh_q};
        `SGSL_OFF_STORM_LOW: rdData_d = stormLow_q;
        `SGSL_OFF_FACT_A: rdData_d = factA_q;
        `SGSL_OFF_FACT_B: rdData_d = factB_q;
        `SGSL_OFF_FACT_C: rdData_d = factC_q;
        `SGSL_OFF_PWR_LED: rdData_d = pwrLed_q;
        `SGSL_OFF_USER_ONE: rdData_d = userOne_q;
        `SGSL_OFF_USER_TWO: rdData_d = userTwo_q;
        default: rdData_d = `SGSL_RST_RSVD;
      endcase
    end
  end

  // reset is synchronous, so the straps are caught on the reset edges themselves
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      stormHigh_q <= `SGSL_RST_STORM_HIGH;
      stormLow_q <= `SGSL_RST_STORM_LOW;
      factA_q <= `SGSL_RST_FACT_A;
      factB_q <= `SGSL_RST_FACT_B;
      factC_q <= `SGSL_RST_FACT_C;
      pwrLed_q <= `SGSL_RST_PWR_LED | {6'h00, ledSelLowStrap, 1'b0};
      userOne_q <= `SGSL_RST_USER;
      userTwo_q <= `SGSL_RST_USER;
      ledHigh_q <= ledSelHighStrap;
      rdData_q <= 8'h00;
      rdValid_q <= 1'b0;
    end
    else
    begin
      stormHigh_q <= stormHigh_d;
      stormLow_q <= stormLow_d;
      factA_q <= factA_d;
      factB_q <= factB_d;
      factC_q <= factC_d;
      pwrLed_q <= pwrLed_d;
      userOne_q <= userOne_d;
      userTwo_q <= userTwo_d;
      ledHigh_q <= ledHigh_d;
      rdData_q <= rdData_d;
      rdValid_q <= rdValid_d;
    end
  end

  // one threshold for all ports
  assign threshold = {stormHigh_q, stormLow_q};

  // a per-port limiter keeps the counters close to the traffic they watch
  for (genvar p = 0; p < NPORTS; p++)
  begin : gPort
    sgsl_storm_port #(
      .PERIOD100_CYC(PERIOD100_CYC),
      .PERIOD10_CYC(PERIOD10_CYC)
    ) uLimiter (
      .clk(clk),
      .nrst(nrst),
      .portIn(portIn[p]),
      .threshold(threshold),
      .dropBcast(dropBcast[p])
    );
  end

  // outputs straight from flops
  assign regRdData = rdData_q;
  assign regRdValid = rdValid_q;
  assign phyPowerSave = pwrLed_q[`SGSL_BIT_PWR_SAVE];
  assign factoryTestMode = pwrLed_q[`SGSL_BIT_TEST_MODE];
  assign specialTpidMode = pwrLed_q[0];
  assign led_mode_sel_low = pwrLed_q[`SGSL_BIT_LED_LOW];
  assign led_mode_sel_high = ledHigh_q;

  // write followed by a read of the same offset
  sequence sWriteThenRead(logic [7:0] off);
    (regReq.wr && regReq.addr == off) ##1 (regReq.rd && !regReq.wr && regReq.addr == off);
  endsequence

  // single strobes at one offset, used as triggers below
  sequence sReadOf(logic [7:0] off);
    regReq.rd && regReq.addr == off;
  endsequence

  sequence sWriteOf(logic [7:0] off);
    regReq.wr && regReq.addr == off;
  endsequence

  AST_THRESH_RESET: assert property (@(posedge clk)
    $rose(nrst) |-> threshold == {`SGSL_RST_STORM_HIGH, `SGSL_RST_STORM_LOW})
    else $error("threshold not at its reset value");

  AST_THRESH_LOW_WRITE: assert property (@(posedge clk) disable iff (!nrst)
    (regReq.wr && regReq.addr == `SGSL_OFF_STORM_LOW) |=>
      threshold[7:0] == $past(regReq.wdata) && $stable(threshold[10:8]))
    else $error("low threshold write mishandled");

  AST_THRESH_HIGH_WRITE: assert property (@(posedge clk) disable iff (!nrst)
    (regReq.wr && regReq.addr == `SGSL_OFF_STORM_HIGH) |=>
      threshold[10:8] == $past(regReq.wdata[2:0]))
    else $error("high threshold write mishandled");

  AST_POWER_SAVE: assert property (@(posedge clk) disable iff (!nrst)
    (regReq.wr && regReq.addr == `SGSL_OFF_PWR_LED) |=>
      phyPowerSave == $past(regReq.wdata[`SGSL_BIT_PWR_SAVE]))
    else $error("power save does not follow its bit");

  AST_LED_LOW_STRAP: assert property (@(posedge clk)
    $rose(nrst) |-> led_mode_sel_low == $past(ledSelLowStrap))
    else $error("low LED selector not taken from strap");

  AST_LED_HIGH_FIXED: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) |-> $stable(led_mode_sel_high))
    else $error("high LED selector changed outside reset");

  AST_SCRATCH_READBACK: assert property (@(posedge clk) disable iff (!nrst)
    sWriteThenRead(`SGSL_OFF_USER_ONE) |=> regRdValid && regRdData == $past(regReq.wdata, 2))
    else $error("user register did not read back");

  AST_RSVD_READ: assert property (@(posedge clk) disable iff (!nrst)
    (regReq.rd && regReq.addr == `SGSL_OFF_RSVD) |=> regRdValid && regRdData == 8'h00)
    else $error("reserved register read nonzero");

  AST_FACT_READBACK: assert property (@(posedge clk) disable iff (!nrst)
    sWriteThenRead(`SGSL_OFF_FACT_A) |=> regRdValid && regRdData == $past(regReq.wdata, 2))
    else $error("factory-test register did not read back");

  // the answer must not linger, or a host polling valid would see a stale read twice
  AST_READ_VALID_PULSE: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) |-> regRdValid == $past(regReq.rd))
    else $error("read valid is not a one-cycle answer to the strobe");

  AST_STORM_HIGH_UPPER: assert property (@(posedge clk) disable iff (!nrst)
    sReadOf(`SGSL_OFF_STORM_HIGH) |=> regRdData[7:3] == 5'h00)
    else $error("upper bits of the high threshold byte read nonzero");

  AST_LED_LOW_WRITE: assert property (@(posedge clk) disable iff (!nrst)
    sWriteOf(`SGSL_OFF_PWR_LED) |=>
      led_mode_sel_low == $past(regReq.wdata[`SGSL_BIT_LED_LOW]) && $stable(led_mode_sel_high))
    else $error("LED selector write mishandled");

  // only the two threshold bytes may move the limit the port counters compare against
  AST_THRESH_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    !(regReq.wr && (regReq.addr == `SGSL_OFF_STORM_HIGH || regReq.addr == `SGSL_OFF_STORM_LOW))
      |=> $stable(threshold))
    else $error("threshold changed without a write to its bytes");
endmodule : sgsl_global_regs

// [verilog/sgsl_pkg.sv]
`include "sgsl_consts.svh"

package sgsl_pkg;
  // one register access from the host port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sgsl_reg_req_s;

  // per-port ingress traffic report
  typedef struct packed {
    logic blockSeen;
    logic isTenMbps;
    logic stormEn;
  } sgsl_port_in_s;

  typedef logic [`SGSL_THRESH_W-1:0] sgsl_thresh_t;
  typedef logic [`SGSL_PERIOD_CNT_W-1:0] sgsl_period_t;
endpackage : sgsl_pkg

// [verilog/sgsl_storm_port.sv]
`include "sgsl_consts.svh"

module sgsl_storm_port #(
  parameter int unsigned PERIOD100_CYC = 32'(`SGSL_PERIOD_100_CYC),
  parameter int unsigned PERIOD10_CYC = 32'(`SGSL_PERIOD_10_CYC)
) (
  input wire logic clk,
  input wire logic nrst,
  input sgsl_pkg::sgsl_port_in_s portIn,
  input sgsl_pkg::sgsl_thresh_t threshold,
  output logic dropBcast
);
  import sgsl_pkg::*;

  localparam sgsl_period_t RELOAD100 = sgsl_period_t'(PERIOD100_CYC - 1);
  localparam sgsl_period_t RELOAD10 = sgsl_period_t'(PERIOD10_CYC - 1);

  if (PERIOD100_CYC < 2 || PERIOD10_CYC < 2 ||
      PERIOD100_CYC > (1 << `SGSL_PERIOD_CNT_W) || PERIOD10_CYC > (1 << `SGSL_PERIOD_CNT_W))
  begin : gPeriodCheck
    $error("period counts out of range for the period counter");
  end

  // limit reached once the count meets the threshold
  function automatic logic atLimit(input sgsl_thresh_t cnt, input sgsl_thresh_t thr);
    return cnt >= thr;
  endfunction : atLimit

  sgsl_period_t periodCnt_q, periodCnt_d;
  sgsl_thresh_t blockCnt_q, blockCnt_d;
  logic drop_q, drop_d;
  logic periodEnd;

  // period timer and block counter; speed is read at each reload
  always_comb
  begin
    periodEnd = (periodCnt_q == '0);
    periodCnt_d = periodCnt_q - sgsl_period_t'(1);
    blockCnt_d = blockCnt_q;
    if (periodEnd)
    begin
      periodCnt_d = portIn.isTenMbps ? RELOAD10 : RELOAD100;
      blockCnt_d = '0;
    end
    // a block in the boundary cycle opens the new period's count
    if (portIn.stormEn && portIn.blockSeen)
    begin
      if (periodEnd)
        blockCnt_d = sgsl_thresh_t'(1);
      else if (!atLimit(blockCnt_q, threshold))
        blockCnt_d = blockCnt_q + sgsl_thresh_t'(1);
    end
    drop_d = portIn.stormEn && atLimit(blockCnt_d, threshold);
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      periodCnt_q <= RELOAD100;
      blockCnt_q <= '0;
      drop_q <= 1'b0;
    end
    else
    begin
      periodCnt_q <= periodCnt_d;
      blockCnt_q <= blockCnt_d;
      drop_q <= drop_d;
    end
  end

  assign dropBcast = drop_q;

  AST_PERIOD_RELOAD: assert property (@(posedge clk) disable iff (!nrst)
    (periodCnt_q == '0) |=> periodCnt_q == ($past(portIn.isTenMbps) ? RELOAD10 : RELOAD100))
    else $error("period counter reloaded with the wrong length");

  AST_PERIOD_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
    (periodCnt_q == '0) |=> blockCnt_q <= sgsl_thresh_t'(1))
    else $error("block count not cleared at period boundary");

  AST_NO_OVERCOUNT: assert property (@(posedge clk) disable iff (!nrst)
    (periodCnt_q != '0 && atLimit(blockCnt_q, threshold)) |=> $stable(blockCnt_q))
    else $error("block count rose past the threshold");
endmodule : sgsl_storm_port
